// >>> src/tfcr_duration_timer.sv
// Purpose: measures thermal-alarm assertion time in ticks, flags overrun
// Assumes: asserted is already synchronised and filtered
// Notes: tick divider restarts at each assertion
`timescale 1ns/1ps
`default_nettype none
module tfcr_duration_timer #(
  parameter int TICK_CYCLES = tfcr_pkg::TICK_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  tfcr_timer_if.timer tif
);
  import tfcr_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("tick period must be at least one cycle");
  end

  logic [TW-1:0] tick_cnt_reg;
  logic asserted_d_reg;
  logic [7:0] ep_cnt_reg;
  logic fired_reg;
  logic [7:0] count_reg;
  logic seen_reg;
  logic evt_reg;
  logic rise;
  logic tick;
  logic fired_eff;
  logic [7:0] ep_base;
  logic [7:0] ep_inc;
  logic fire;

  assign rise = tif.asserted && !asserted_d_reg;
  assign tick = tif.asserted && (tick_cnt_reg == TICK_LAST);
  assign fired_eff = rise ? 1'b0 : fired_reg;
  assign ep_base = rise ? RST_ZERO : ep_cnt_reg;
  assign ep_inc = (ep_base == COUNT_MAX) ? COUNT_MAX : ep_base + 8'h01;
  // zero limit fires on the assertion itself
  assign fire = tif.asserted && !fired_eff &&
                ((tif.limit == RST_ZERO) ||
                 (tick && (ep_inc > tif.limit)));

  // ***************************************************************
  // tick divider and episode tracking
  // ***************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_reg <= '0;
      asserted_d_reg <= 1'b0;
    end
    else if (ce)
    begin
      asserted_d_reg <= tif.asserted;
      if (!tif.asserted || tick)
        tick_cnt_reg <= '0;
      else
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // one flag per episode: limit 0xff can never be exceeded
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ep_cnt_reg <= RST_ZERO;
      fired_reg <= 1'b0;
      evt_reg <= 1'b0;
    end
    else if (ce)
    begin
      ep_cnt_reg <= tick ? ep_inc : ep_base;
      fired_reg <= fired_eff || fire;
      evt_reg <= fire;
    end
  end

  // ***************************************************************
  // software-visible accumulated time, read clears, set wins
  // ***************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= RST_ZERO;
      seen_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (tick)
        count_reg <= tif.rd_clear ? 8'h01 :
                     (count_reg == COUNT_MAX) ? COUNT_MAX :
                     count_reg + 8'h01;
      else if (tif.rd_clear)
        count_reg <= RST_ZERO;
      if (rise)
        seen_reg <= 1'b1;
      else if (tif.rd_clear)
        seen_reg <= 1'b0;
    end
  end

  assign tif.count = count_reg;
  assign tif.seen = seen_reg;
  assign tif.limit_evt = evt_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  a_zero_limit_fire: assert property (
    (rise && tif.limit == RST_ZERO) |=> evt_reg)
    else $error("zero limit did not fire on assertion");
  a_evt_once: assert property (
    evt_reg |=> !evt_reg)
    else $error("limit event repeated");
  a_evt_cause: assert property (
    evt_reg |-> $past(tif.asserted))
    else $error("limit event without assertion");
  a_seen_rise: assert property (
    rise |=> seen_reg)
    else $error("assertion not recorded");

endmodule : tfcr_duration_timer
`default_nettype wire

// >>> src/tfcr_pkg.sv
// Purpose: shared constants for the thermal and fan configuration bank
// Assumes: 32-bit AXI4-Lite data, registers in the low byte of each word
// Notes: byte address of a register is four times its index
package tfcr_pkg;

  // ***************************************************************
  // bus geometry
  // ***************************************************************
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int IDX_W = 7;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************************
  // register indices
  // ***************************************************************
  localparam logic [IDX_W-1:0] IDX_CTRL = 7'h40;
  localparam logic [IDX_W-1:0] IDX_STAT2 = 7'h42;
  localparam logic [IDX_W-1:0] IDX_MASK2 = 7'h75;
  localparam logic [IDX_W-1:0] IDX_TSTAT = 7'h79;
  localparam logic [IDX_W-1:0] IDX_LIMIT = 7'h7a;
  localparam logic [IDX_W-1:0] IDX_PULSE = 7'h7b;
  localparam logic [IDX_W-1:0] IDX_CFG4 = 7'h7d;
  localparam logic [IDX_W-1:0] IDX_TESTA = 7'h7e;
  localparam logic [IDX_W-1:0] IDX_TESTB = 7'h7f;

  // ***************************************************************
  // reset values and field layout
  // ***************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PULSE = 8'h55;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] CFG4_WMASK = 8'h0d;
  localparam logic [7:0] CTRL_WMASK = 8'h03;
  localparam logic [7:0] CTRL_LOCK_MASK = 8'h01;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_T4_THERMAL_ALARM_PIN_BIT = 1;
  localparam int CFG4_ALERT_BIT = 0;
  localparam int CFG4_THR_LSB = 2;
  localparam int TMR_EVT_BIT = 5;
  localparam int TSTAT_SEEN_BIT = 0;
  localparam int NUM_TACH = 4;
  localparam int PULSE_W = 2;
  localparam logic [2:0] PULSES_RST = 3'h2;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam real TICK_MS = 22.76;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int TICK_CYCLES_DEF = int'(TICK_MS * 1.0e6 / CLK_PERIOD_NS);

endpackage : tfcr_pkg

// >>> src/tfcr_regs.sv
// Purpose: thermal limit, tach pulse select, pin config and test registers
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes: only byte lane 0 carries register data
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - eight-bit read/write assertion limit, 22.76 ms per count
// - exceeding the limit sets bit 5 of interrupt status two
// - a zero limit raises the flag as soon as the alarm asserts
// - two-bit field per tach channel selects one to four pulses
// - pulse select register resets to 0x55, two pulses each
// - config four bit 0 picks alert output or 2.5 V input
// - config four bits 3:2 pick the 2-wire fan input threshold
// - with lock set, writes to config four are silently ignored
// - both test registers read zero and ignore writes
// - config four bit 1 reserved read-only, bits 7:4 unused
// - timer status lsb set on assertion, cleared by its read
// - fan-4 mask bit masks timer events when tach_input_ch4 is the alarm
module tfcr_regs #(
  parameter int TICK_CYCLES = tfcr_pkg::TICK_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [tfcr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tfcr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tfcr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tfcr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic thermal_alarm_pin_n,
  output logic irq,
  output logic alert_out_n,
  output logic alert_oe,
  output logic alert_pin_function_select,
  output logic [1:0] two_wire_input_threshold,
  output logic [tfcr_pkg::NUM_TACH-1:0][2:0] tach_pulse_count
);
  import tfcr_pkg::*;

  if (TICK_CYCLES < 2)
  begin : g_bad_tick
    $error("tick period too short for the duration timer");
  end

  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      IDX_CTRL, IDX_STAT2, IDX_MASK2, IDX_TSTAT, IDX_LIMIT,
      IDX_PULSE, IDX_CFG4, IDX_TESTA, IDX_TESTB: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : idx_mapped

  function automatic logic [2:0] pulses_of(input logic [PULSE_W-1:0] code);
    return {1'b0, code} + 3'h1;
  endfunction : pulses_of

  // ***************************************************************
  // alarm input: three flops, a change counts when two and three agree
  // ***************************************************************
  logic sync1_reg, sync2_reg, sync3_reg, alarm_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end
    else if (ce)
    begin
      sync1_reg <= !thermal_alarm_pin_n;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg)
        alarm_reg <= sync3_reg;
    end
  end

  // ***************************************************************
  // register storage
  // ***************************************************************
  logic [7:0] limit_reg, pulse_reg, cfg4_reg, mask_reg, ctrl_reg;
  logic [7:0] stat_reg, stat_next;
  logic aw_have_reg, w_have_reg, awready_reg, wready_reg;
  logic [ADDR_W-1:0] awaddr_hold_reg;
  logic [7:0] wdata_hold_reg;
  logic wlane0_hold_reg;
  logic bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic wr_fire, wr_en, ar_take, stat_rd, evt, locked;
  logic [IDX_W-1:0] wr_idx, rd_idx;

  tfcr_timer_if tif ();

  assign wr_idx = awaddr_hold_reg[IDX_LSB +: IDX_W];
  assign rd_idx = s_axi_araddr[IDX_LSB +: IDX_W];
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_en = wr_fire && wlane0_hold_reg;
  assign ar_take = s_axi_arvalid && arready_reg;
  assign stat_rd = ar_take && (rd_idx == IDX_STAT2);
  assign locked = ctrl_reg[CTRL_LOCK_BIT];
  assign evt = tif.limit_evt;

  // the timer sees the alarm only while tach_input_ch4 serves as its input
  assign tif.asserted = alarm_reg && ctrl_reg[CTRL_T4_THERMAL_ALARM_PIN_BIT];
  assign tif.limit = limit_reg;
  assign tif.rd_clear = ar_take && (rd_idx == IDX_TSTAT);

  tfcr_duration_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tif(tif.timer)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      limit_reg <= RST_ZERO;
      pulse_reg <= RST_PULSE;
      mask_reg <= RST_ZERO;
    end
    else if (ce && wr_en)
    begin
      if (wr_idx == IDX_LIMIT)
        limit_reg <= wdata_hold_reg;
      if (wr_idx == IDX_PULSE)
        pulse_reg <= wdata_hold_reg;
      if (wr_idx == IDX_MASK2)
        mask_reg <= wdata_hold_reg;
    end
  end

  // lock is sticky until reset; reserved bits never store
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg4_reg <= RST_ZERO;
      ctrl_reg <= RST_ZERO;
    end
    else if (ce && wr_en)
    begin
      if (wr_idx == IDX_CFG4 && !locked)
        cfg4_reg <= wdata_hold_reg & CFG4_WMASK;
      if (wr_idx == IDX_CTRL)
        ctrl_reg <= (wdata_hold_reg & CTRL_WMASK) |
                    (ctrl_reg & CTRL_LOCK_MASK);
    end
  end

  // ***************************************************************
  // interrupt status, mask and outputs
  // ***************************************************************
  always_comb
  begin
    stat_next = stat_reg;
    if (stat_rd)
      stat_next = RST_ZERO;
    if (evt)
      stat_next[TMR_EVT_BIT] = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_reg <= RST_ZERO;
      irq <= 1'b0;
      alert_out_n <= 1'b1;
      alert_oe <= 1'b0;
    end
    else if (ce)
    begin
      stat_reg <= stat_next;
      irq <= |(stat_next & ~mask_reg);
      alert_out_n <= !(cfg4_reg[CFG4_ALERT_BIT] &&
                       |(stat_next & ~mask_reg));
      alert_oe <= cfg4_reg[CFG4_ALERT_BIT];
    end
  end

  assign alert_pin_function_select = cfg4_reg[CFG4_ALERT_BIT];
  assign two_wire_input_threshold = cfg4_reg[CFG4_THR_LSB +: 2];

  logic [NUM_TACH-1:0][2:0] pulses_next;
  logic [NUM_TACH-1:0][2:0] pulses_reg;
  for (genvar g = 0; g < NUM_TACH; g++)
  begin : g_tach
    assign pulses_next[g] = pulses_of(pulse_reg[g*PULSE_W +: PULSE_W]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pulses_reg <= {NUM_TACH{PULSES_RST}};
    else if (ce)
      pulses_reg <= pulses_next;
  end
  assign tach_pulse_count = pulses_reg;

  // ***************************************************************
  // AXI4-Lite write channels
  // ***************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      awready_reg <= 1'b0;
      awaddr_hold_reg <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        aw_have_reg <= 1'b1;
        awaddr_hold_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      else if (wr_fire)
      begin
        aw_have_reg <= 1'b0;
        awready_reg <= 1'b1;
      end
      else if (!aw_have_reg)
        awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_reg <= 1'b0;
      wready_reg <= 1'b0;
      wdata_hold_reg <= RST_ZERO;
      wlane0_hold_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && wready_reg)
      begin
        w_have_reg <= 1'b1;
        wdata_hold_reg <= s_axi_wdata[7:0];
        wlane0_hold_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end
      else if (wr_fire)
      begin
        w_have_reg <= 1'b0;
        wready_reg <= 1'b1;
      end
      else if (!w_have_reg)
        wready_reg <= 1'b1;
    end
  end

  // writes to read-only words are accepted and dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ***************************************************************
  // AXI4-Lite read channels
  // ***************************************************************
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = RST_ZERO;
    case (rd_idx)
      IDX_CTRL: rd_byte = ctrl_reg;
      IDX_STAT2: rd_byte = stat_reg;
      IDX_MASK2: rd_byte = mask_reg;
      IDX_TSTAT: rd_byte = {tif.count[7:1],
                            tif.seen | tif.count[TSTAT_SEEN_BIT]};
      IDX_LIMIT: rd_byte = limit_reg;
      IDX_PULSE: rd_byte = pulse_reg;
      IDX_CFG4: rd_byte = cfg4_reg;
      IDX_TESTA: rd_byte = RST_TEST;
      IDX_TESTB: rd_byte = RST_TEST;
      default: rd_byte = RST_ZERO;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        arready_reg <= 1'b0;
        rdata_reg <= {{(DATA_W-8){1'b0}}, rd_byte};
        rresp_reg <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
      else if (!rvalid_reg)
        arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  sequence s_rd_take;
    s_axi_arvalid && arready_reg;
  endsequence
  sequence s_cfg4_wr_locked;
    wr_en && (wr_idx == IDX_CFG4) && locked;
  endsequence

  a_lock_holds_cfg4: assert property (
    s_cfg4_wr_locked |=> $stable(cfg4_reg))
    else $error("locked config register changed");
  a_cfg4_reserved: assert property (
    (cfg4_reg & ~CFG4_WMASK) == RST_ZERO)
    else $error("reserved config bits set");
  a_stat_rd_clear: assert property (
    (s_rd_take ##0 (rd_idx == IDX_STAT2 && !evt)) |=>
      !stat_reg[TMR_EVT_BIT])
    else $error("status read did not clear event");
  a_stat_set_wins: assert property (
    (evt && stat_rd) |=> stat_reg[TMR_EVT_BIT])
    else $error("event lost under read clear");
  a_evt_to_irq: assert property (
    (evt && !mask_reg[TMR_EVT_BIT]) |=> irq)
    else $error("unmasked event did not raise irq");
  a_masked_no_irq: assert property (
    (mask_reg[TMR_EVT_BIT] && $past(mask_reg[TMR_EVT_BIT])) |-> !irq)
    else $error("irq despite full mask");
  a_test_reads_zero: assert property (
    (s_rd_take ##0 (rd_idx == IDX_TESTA || rd_idx == IDX_TESTB))
      |=> (s_axi_rvalid && s_axi_rdata == '0))
    else $error("test register read nonzero");
  a_pulse_decode: assert property (
    ##1 (tach_pulse_count[0] == $past(pulse_reg[1:0]) + 3'h1))
    else $error("pulse count decode wrong");
  a_rdata_hold: assert property (
    (s_axi_rvalid && !s_axi_rready) |=>
      (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped before ready");

endmodule : tfcr_regs
`default_nettype wire

// >>> src/tfcr_timer_if.sv
// Purpose: carries the duration timer's controls and results
// Assumes: both ends on aclk
// Notes: ctrl end is the register bank, timer end the counter
`timescale 1ns/1ps
`default_nettype none
interface tfcr_timer_if;
  logic asserted;
  logic [7:0] limit;
  logic rd_clear;
  logic [7:0] count;
  logic seen;
  logic limit_evt;
  modport ctrl (output asserted, limit, rd_clear,
                input count, seen, limit_evt);
  modport timer (input asserted, limit, rd_clear,
                 output count, seen, limit_evt);
endinterface : tfcr_timer_if
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the thermal and fan config registers
// Assumes: tick divider cut to 4 cycles so alarm episodes stay short
// Notes: table rows first, then pin config, alarm timer and lock cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tfcr_pkg::*;
  localparam int TICK = 4;
  logic aclk, aresetn, ce, pin_n, irq, alert_out_n, alert_oe, alert_sel;
  logic [1:0] thr, bresp, rresp, resp;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0][2:0] pulses;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  // rows: response, index, data written, data read back
  localparam logic [24:0] ROWS [6] = '{
    {2'h0, 7'h7a, 8'ha5, 8'ha5}, {2'h0, 7'h7b, 8'he4, 8'he4},
    {2'h0, 7'h7d, 8'hff, 8'h0d}, {2'h0, 7'h7e, 8'hff, 8'h00},
    {2'h0, 7'h7f, 8'hff, 8'h00}, {2'h2, 7'h10, 8'hff, 8'h00}};

  tfcr_regs #(.TICK_CYCLES(TICK)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .thermal_alarm_pin_n(pin_n), .irq(irq),
    .alert_out_n(alert_out_n), .alert_oe(alert_oe),
    .alert_pin_function_select(alert_sel),
    .two_wire_input_threshold(thr), .tach_pulse_count(pulses));

  tfcr_host_model host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // ************************************************************
  // clock, timeout and helpers
  // ************************************************************
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [6:0] idx, input logic [7:0] e);
    host.rd(idx, d, resp);
    chk(d, 32'(e));
  endtask : rdchk

  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < n)
    begin
      @(posedge aclk);
      k++;
    end
  endtask : wait_irq

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    aresetn = 1'b0;
    ce = 1'b1;
    pin_n = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(pulses), 32'({4{3'h2}}));
    chk(32'(alert_oe), 32'h0);
    rdchk(IDX_PULSE, 8'h55);
    rdchk(IDX_LIMIT, 8'h00);
    foreach (ROWS[i])
    begin
      host.wr(ROWS[i][22:16], ROWS[i][15:8], resp);
      chk(32'(resp), 32'(ROWS[i][24:23]));
      rdchk(ROWS[i][22:16], ROWS[i][7:0]);
      chk(32'(resp), 32'(ROWS[i][24:23]));
    end
    chk(32'(pulses), 32'({3'h4, 3'h3, 3'h2, 3'h1}));
    // last code leaves the pin as alert output for the timer cases
    for (int c = 0; c < 4; c++)
    begin
      host.wr(IDX_CFG4, {4'h0, 2'(c), 1'b0, 1'(c)}, resp);
      repeat (2) @(posedge aclk);
      chk(32'(thr), 32'(c));
      chk(32'({alert_sel, alert_oe}), 32'({2{1'(c)}}));
    end
    host.wr(IDX_CTRL, 8'h02, resp);
    host.wr(IDX_LIMIT, 8'h00, resp);
    // with the enable low the alarm must not even reach the synchroniser
    {ce, pin_n} <= 2'b00;
    repeat (12) @(posedge aclk);
    chk(32'(irq), 32'h0);
    ce <= 1'b1;
    wait_irq(8);
    chk(32'(irq), 32'h1);
    chk(32'(alert_out_n), 32'h0);
    rdchk(IDX_STAT2, 8'h20);
    rdchk(IDX_STAT2, 8'h00);
    host.rd(IDX_TSTAT, d, resp);
    chk(32'(d[0]), 32'h1);
    pin_n <= 1'b1;
    host.wr(IDX_LIMIT, 8'h03, resp);
    host.rd(IDX_STAT2, d, resp);
    pin_n <= 1'b0;
    // fourth tick exceeds a limit of three; the status read is timed to
    // land on the event edge, so the flag must survive its own clear
    repeat (19) @(posedge aclk);
    chk(32'(irq), 32'h0);
    host.rd(IDX_STAT2, d, resp);
    wait_irq(4);
    chk(32'(irq), 32'h1);
    chk(32'(d), 32'h0);
    host.wr(IDX_MASK2, 8'h20, resp);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    rdchk(IDX_STAT2, 8'h20);
    host.wr(IDX_CTRL, 8'h03, resp);
    host.wr(IDX_CFG4, 8'h00, resp);
    chk(32'(resp), 32'h0);
    rdchk(IDX_CFG4, 8'h0d);
    // mid-run reset: defaults return and the lock no longer holds
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({pulses, irq, alert_oe}), 32'({{4{3'h2}}, 2'h0}));
    host.wr(IDX_CFG4, 8'h01, resp);
    rdchk(IDX_CFG4, 8'h01);
    rdchk(IDX_PULSE, 8'h55);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// >>> tb/tfcr_host_model.sv
// Purpose: host side of the register bus, one AXI4-Lite cycle per call
// Assumes: the bench calls one task at a time, on aclk
// Notes: no latency is assumed, the slave's answer ends each wait
`timescale 1ns/1ps
`default_nettype none
module tfcr_host_model (
  input wire logic aclk,
  output logic [tfcr_pkg::ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [tfcr_pkg::DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [tfcr_pkg::ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [tfcr_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  import tfcr_pkg::*;
  // ************************************************************
  // bus cycles
  // ************************************************************
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // address and data go out together; each drops once taken
  task automatic wr(input logic [6:0] idx, input logic [7:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h00_0000, d};
    {awvalid, wvalid, bready} <= 3'h7;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    {arvalid, rready} <= 2'h3;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : tfcr_host_model
`default_nettype wire
